/* File: arpc_consts.svh */
/*
 Holds the shared constants of the alarm relay and panel control block: reset values, field widths and timing counts.
 Assumes inclusion by bare name from the relay driver and top modules.
*/
`ifndef ARPC_CONSTS_SVH
`define ARPC_CONSTS_SVH
// ==================================================
// Timing
`define ARPC_CLK_HZ 50000000
`define ARPC_BL_TIMEOUT_MIN 5
// Written out as sized literals: the products overflow 32-bit integer arithmetic
// Five minutes at 50 MHz
`define ARPC_BL_TIMEOUT_CYC 34'h37e11d600
// One minute at 50 MHz
`define ARPC_RELOCK_CYC_PER_MIN 34'h0b2d05e00
// ==================================================
// Widths and reset values
`define ARPC_TMR_W 34
`define ARPC_CONTRAST_RST 7'h32
`define ARPC_CONTRAST_MAX 7'h64
`define ARPC_CODE_RST 16'h0000
`define ARPC_NUM_RELAYS 3
`define ARPC_NUM_ALARMS 4
`endif

/* File: arpc_pkg.sv */
/*
 Holds the types of the alarm relay and panel control block.
 Assumes arpc_consts.svh is available.
*/
package arpc_pkg;
   // ==================================================
   // Backlight modes
   typedef enum logic [1:0] {
      ARPC_BL_MANUAL = 2'h0,
      ARPC_BL_AUTO = 2'h1,
      ARPC_BL_NEVER = 2'h2,
      ARPC_BL_ALWAYS = 2'h3
   } arpc_bl_mode_t;
   // Panel lock states
   typedef enum logic [1:0] {
      ARPC_LOCKED,
      ARPC_OPEN,
      ARPC_OPEN_TIMED
   } arpc_lock_t;
endpackage

/* File: arpc_sync.sv */
/*
 Holds a two flip-flop level synchroniser for pin inputs.
 Assumes a single clock domain at core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module arpc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_dout;
   // ==================================================
   // First stage feeds the second stage only
   always_comb begin
      next_meta = din;
      next_dout = meta;
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= next_meta;
         dout <= next_dout;
      end
   end
endmodule
`default_nettype wire

/* File: arpc_relay_drv.sv */
/*
 Holds the coil driver for one alarm relay: alarm select and rest polarity.
 Assumes alarm inputs are already synchronised to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "arpc_consts.svh"
module arpc_relay_drv import arpc_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Configuration
   input wire logic [1:0] alarmSel,
   input wire logic restPolarity,
   // Alarm conditions
   input wire logic [`ARPC_NUM_ALARMS-1:0] alarmActive,
   // Coil
   output logic coilOn
);
   logic next_coilOn;
   // ==================================================
   // Polarity 0 energizes on alarm, polarity 1 is fail-safe
   always_comb begin
      next_coilOn = alarmActive[alarmSel] ^ restPolarity;
   end
   // Reset leaves the coil off, matching the powerless state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         coilOn <= 1'b0;
      end else begin
         coilOn <= next_coilOn;
      end
   end
   a_coil_follows: assert property (@(posedge core_clk) disable iff (rst)
      1'b1 |=> coilOn == ($past(alarmActive[alarmSel]) ^ $past(restPolarity)))
      else $error("coil does not follow selected alarm");
   a_failsafe_drop: assert property (@(posedge core_clk) disable iff (rst)
      (restPolarity && alarmActive[alarmSel]) ##1 restPolarity |-> !coilOn)
      else $error("fail-safe coil energized during alarm");
endmodule
`default_nettype wire

/* File: arpc_top.sv */
/*
 Holds the alarm relay and panel control block: three relay coil drivers, the LCD backlight
 controller with its key inactivity timeout, the contrast setting, and the panel security lock.
 Assumes keypad and alarm lines come from pins; settings come from same-clock logic as pulses.
*/
// Contract
// - Three coil outputs, each following one selected alarm out of four.
// - Polarity 0: coil off without alarm, on with alarm.
// - Polarity 1: coil on without alarm, off with alarm.
// - Fail-safe off coil means alarm or power loss; reset keeps coils off.
// - Manual mode: key press lights backlight, five idle minutes turn it off.
// - Auto mode: key or alarm lights it; off after idle with no alarm.
// - Never-on mode holds backlight off; always-on mode holds it on.
// - Backlight lights only when powered in three or four wire mode.
// - Contrast 0 to 100 percent, reset value 50 percent.
// - While locked, reads allowed, changes and methods refused.
// - Unlock only with correct four-digit code; lock state is reported.
// - Timed unlock relocks automatically after the chosen period.
`timescale 1ns/100ps
`default_nettype none
`include "arpc_consts.svh"
module arpc_top import arpc_pkg::*; #(
   parameter logic [`ARPC_TMR_W-1:0] BL_TIMEOUT_CYC = `ARPC_BL_TIMEOUT_CYC,
   parameter logic [`ARPC_TMR_W-1:0] RELOCK_CYC_PER_MIN = `ARPC_RELOCK_CYC_PER_MIN
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Pins: keypad, alarms, supply mode
   input wire logic keyPress,
   input wire logic [`ARPC_NUM_ALARMS-1:0] alarmActive,
   input wire logic multiWirePower,
   // Relay configuration (0..2 packed, 2 select bits and 1 polarity bit each)
   input wire logic [5:0] relayAlarmSel,
   input wire logic [2:0] relayPolarity,
   // Settings requests from the menu logic
   input wire logic setReq,
   input wire logic [1:0] setBlMode,
   input wire logic [6:0] setContrast,
   input wire logic methodReq,
   // Security requests
   input wire logic lockReq,
   input wire logic unlockReq,
   input wire logic unlockTimed,
   input wire logic [7:0] unlockMinutes,
   input wire logic [15:0] codeEntry,
   input wire logic [15:0] codeStored,
   // Outputs
   output logic [2:0] relayCoil,
   output logic backlightOn,
   output logic [6:0] contrast,
   output logic [1:0] blMode,
   output logic panelLocked,
   output logic reqRejected,
   output logic methodGo
);
   // ==================================================
   // Pin synchronisers
   logic keySync;
   logic [`ARPC_NUM_ALARMS-1:0] alarmSync;
   logic powerSync;
   logic keyPrev;
   logic next_keyPrev;
   logic keyEdge;
   arpc_sync #(.W(`ARPC_NUM_ALARMS + 2)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .din({keyPress, multiWirePower, alarmActive}),
      .dout({keySync, powerSync, alarmSync})
   );
   // Key edge after synchronisation
   always_comb begin
      next_keyPrev = keySync;
   end
   always_ff @(posedge core_clk) begin
      if (rst) keyPrev <= 1'b0;
      else keyPrev <= next_keyPrev;
   end
   assign keyEdge = keySync && !keyPrev;

   // ==================================================
   // Relay coil drivers
   genvar gi;
   generate
      for (gi = 0; gi < `ARPC_NUM_RELAYS; gi++) begin : g_relay
         arpc_relay_drv u_relay (
            .core_clk(core_clk),
            .rst(rst),
            .alarmSel(relayAlarmSel[2*gi +: 2]),
            .restPolarity(relayPolarity[gi]),
            .alarmActive(alarmSync),
            .coilOn(relayCoil[gi])
         );
      end
   endgenerate

   // ==================================================
   // Panel security
   arpc_lock_t lockState;
   arpc_lock_t next_lockState;
   logic [`ARPC_TMR_W-1:0] minTmr;
   logic [`ARPC_TMR_W-1:0] next_minTmr;
   logic [7:0] minLeft;
   logic [7:0] next_minLeft;
   logic next_panelLocked;
   logic codeOk;
   assign codeOk = (codeEntry == codeStored);
   // Only the four-digit code opens the panel; a timed open counts down minutes
   always_comb begin
      next_lockState = lockState;
      next_minTmr = minTmr;
      next_minLeft = minLeft;
      unique case (lockState)
         ARPC_LOCKED: begin
            if (unlockReq && codeOk) begin
               next_lockState = unlockTimed ? ARPC_OPEN_TIMED : ARPC_OPEN;
               next_minTmr = '0;
               next_minLeft = (unlockMinutes == 8'h00) ? 8'h01 : unlockMinutes;
            end
         end
         ARPC_OPEN: begin
            if (lockReq) next_lockState = ARPC_LOCKED;
         end
         ARPC_OPEN_TIMED: begin
            if (lockReq) begin
               next_lockState = ARPC_LOCKED;
            end else if (minTmr == RELOCK_CYC_PER_MIN - 1'b1) begin
               next_minTmr = '0;
               next_minLeft = minLeft - 8'h01;
               if (minLeft == 8'h01) next_lockState = ARPC_LOCKED;
            end else begin
               next_minTmr = minTmr + 1'b1;
            end
         end
         default: next_lockState = ARPC_LOCKED;
      endcase
      next_panelLocked = (next_lockState == ARPC_LOCKED);
   end
   // Reset comes up locked: the safe side for a field instrument
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lockState <= ARPC_LOCKED;
         minTmr <= '0;
         minLeft <= 8'h00;
         panelLocked <= 1'b1;
      end else begin
         lockState <= next_lockState;
         minTmr <= next_minTmr;
         minLeft <= next_minLeft;
         panelLocked <= next_panelLocked;
      end
   end

   // ==================================================
   // Settings: contrast and backlight mode, guarded by the lock
   logic [6:0] next_contrast;
   logic [1:0] next_blMode;
   logic next_reqRejected;
   logic next_methodGo;
   always_comb begin
      next_contrast = contrast;
      next_blMode = blMode;
      next_reqRejected = 1'b0;
      next_methodGo = 1'b0;
      if (setReq || methodReq) begin
         if (panelLocked) begin
            next_reqRejected = 1'b1;
         end else begin
            next_methodGo = methodReq;
            if (setReq) begin
               next_blMode = setBlMode;
               // Values above full scale clamp instead of wrapping
               next_contrast = (setContrast > `ARPC_CONTRAST_MAX) ? `ARPC_CONTRAST_MAX : setContrast;
            end
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         contrast <= `ARPC_CONTRAST_RST;
         blMode <= ARPC_BL_MANUAL;
         reqRejected <= 1'b0;
         methodGo <= 1'b0;
      end else begin
         contrast <= next_contrast;
         blMode <= next_blMode;
         reqRejected <= next_reqRejected;
         methodGo <= next_methodGo;
      end
   end

   // ==================================================
   // Backlight with key inactivity timer
   logic [`ARPC_TMR_W-1:0] idleTmr;
   logic [`ARPC_TMR_W-1:0] next_idleTmr;
   logic idleExpired;
   logic next_idleExpired;
   logic next_backlightOn;
   logic anyAlarm;
   logic wantOn;
   assign anyAlarm = |alarmSync;
   // The timer saturates so a long-idle panel never wraps back on
   always_comb begin
      next_idleTmr = idleTmr;
      next_idleExpired = idleExpired;
      if (keyEdge) begin
         next_idleTmr = '0;
         next_idleExpired = 1'b0;
      end else if (!idleExpired) begin
         if (idleTmr == BL_TIMEOUT_CYC - 1'b1) next_idleExpired = 1'b1;
         else next_idleTmr = idleTmr + 1'b1;
      end
      unique case (arpc_bl_mode_t'(blMode))
         ARPC_BL_MANUAL: wantOn = !next_idleExpired;
         ARPC_BL_AUTO: wantOn = !next_idleExpired || anyAlarm;
         ARPC_BL_NEVER: wantOn = 1'b0;
         ARPC_BL_ALWAYS: wantOn = 1'b1;
      endcase
      next_backlightOn = wantOn && powerSync;
   end
   // Reset counts as expired so the light stays dark until a key
   always_ff @(posedge core_clk) begin
      if (rst) begin
         idleTmr <= '0;
         idleExpired <= 1'b1;
         backlightOn <= 1'b0;
      end else begin
         idleTmr <= next_idleTmr;
         idleExpired <= next_idleExpired;
         backlightOn <= next_backlightOn;
      end
   end

   // ==================================================
   // Checks
   a_bl_power_gate: assert property (@(posedge core_clk) disable iff (rst)
      !powerSync |=> !backlightOn)
      else $error("backlight on without multi-wire power");
   a_bl_never_off: assert property (@(posedge core_clk) disable iff (rst)
      blMode == ARPC_BL_NEVER |=> !backlightOn)
      else $error("backlight on in never mode");
   a_bl_always_on: assert property (@(posedge core_clk) disable iff (rst)
      (blMode == ARPC_BL_ALWAYS && powerSync) |=> backlightOn)
      else $error("backlight off in always mode");
   a_bl_key_on: assert property (@(posedge core_clk) disable iff (rst)
      (keyEdge && powerSync && blMode == ARPC_BL_MANUAL) |=> backlightOn)
      else $error("key press did not light backlight");
   a_bl_auto_alarm: assert property (@(posedge core_clk) disable iff (rst)
      (anyAlarm && powerSync && blMode == ARPC_BL_AUTO) |=> backlightOn)
      else $error("alarm did not light backlight in auto mode");
   a_key_restart: assert property (@(posedge core_clk) disable iff (rst)
      keyEdge |=> idleTmr == '0 && !idleExpired)
      else $error("key press did not restart idle timer");
   a_lock_reject: assert property (@(posedge core_clk) disable iff (rst)
      (panelLocked && (setReq || methodReq)) |=> reqRejected && !methodGo && $stable(contrast))
      else $error("locked panel accepted a change");
   a_bad_code: assert property (@(posedge core_clk) disable iff (rst)
      (lockState == ARPC_LOCKED && !codeOk) |=> panelLocked)
      else $error("panel opened with wrong code");
   a_contrast_range: assert property (@(posedge core_clk) disable iff (rst)
      contrast <= `ARPC_CONTRAST_MAX)
      else $error("contrast above full scale");
   a_timed_relock: assert property (@(posedge core_clk) disable iff (rst)
      (lockState == ARPC_OPEN_TIMED && minLeft == 8'h01 && minTmr == RELOCK_CYC_PER_MIN - 1'b1)
      |=> panelLocked)
      else $error("timed unlock did not relock");

   // ==================================================
   // Further checks on lock, settings and light
   // A locked panel never starts a method
   a_no_method_locked: assert property (@(posedge core_clk) disable iff (rst)
      panelLocked |=> !methodGo)
      else $error("method started while locked");
   // An open panel runs a requested method
   a_method_open: assert property (@(posedge core_clk) disable iff (rst)
      (!panelLocked && methodReq) |=> methodGo && !reqRejected)
      else $error("method refused while open");
   // Settings only move with an accepted set request
   a_settings_hold: assert property (@(posedge core_clk) disable iff (rst)
      !setReq |=> $stable(contrast) && $stable(blMode))
      else $error("settings changed without a request");
   // An accepted set takes the requested mode
   a_set_mode: assert property (@(posedge core_clk) disable iff (rst)
      (!panelLocked && setReq) |=> blMode == $past(setBlMode))
      else $error("accepted set lost the mode");
   // A lock request closes an open panel
   a_lock_request: assert property (@(posedge core_clk) disable iff (rst)
      (lockReq && lockState != ARPC_LOCKED) |=> panelLocked)
      else $error("lock request ignored");
   // A timed open stays open until its minute count runs out
   a_timed_holds: assert property (@(posedge core_clk) disable iff (rst)
      (lockState == ARPC_OPEN_TIMED && !lockReq && minTmr != RELOCK_CYC_PER_MIN - 1'b1) |=> !panelLocked)
      else $error("timed unlock closed early");
   // A timed open never starts with zero minutes left
   a_timed_minutes: assert property (@(posedge core_clk) disable iff (rst)
      (lockState == ARPC_LOCKED && unlockReq && codeOk && unlockTimed) |=> minLeft != 8'h00)
      else $error("timed unlock with no period");
   // Manual light stays dark once idle and no key comes
   a_manual_dark: assert property (@(posedge core_clk) disable iff (rst)
      (blMode == ARPC_BL_MANUAL && idleExpired && !keyEdge) |=> !backlightOn)
      else $error("manual backlight on while idle");
   // Auto light stays dark once idle with no alarm
   a_auto_dark: assert property (@(posedge core_clk) disable iff (rst)
      (blMode == ARPC_BL_AUTO && idleExpired && !keyEdge && !anyAlarm) |=> !backlightOn)
      else $error("auto backlight on while idle without alarm");
endmodule
`default_nettype wire

/* File: arpc_panel_model.sv */
/*
 Holds a behavioural model of the panel's far side: the keypad and the alarm condition lines.
 Assumes the bench commands key presses and alarm levels, changing them just after core_clk rises.
*/
`timescale 1ns/100ps
`default_nettype none
module arpc_panel_model (
   // Clock
   input wire logic core_clk,
   // Commands from the bench
   input wire logic pressCmd,
   input wire logic [3:0] alarmCmd,
   // Pins toward the block
   output logic keyPress,
   output var logic [3:0] alarmActive
);
   logic [1:0] holdCnt = 2'h0;
   // ==================================================
   // Keypad
   // A press holds the key for three cycles, like a finger; a shorter blip could slip past the sync
   always @(posedge core_clk) begin
      if (pressCmd) begin
         holdCnt <= 2'h3;
      end else if (holdCnt != 2'h0) begin
         holdCnt <= holdCnt - 2'h1;
      end
   end
   assign keyPress = (holdCnt != 2'h0);
   // ==================================================
   // Alarm lines follow the commanded levels
   always @(posedge core_clk) begin
      alarmActive <= alarmCmd;
   end
endmodule
`default_nettype wire

/* File: alarm_relay_and_panel_control_tb_top.sv */
/*
 Holds the self-checking testbench of the alarm relay and panel control block.
 Assumes the block is built with short timeout and relock counts so the run stays brief.
*/
`timescale 1ns/100ps
`default_nettype none
module alarm_relay_and_panel_control_tb_top;
   import arpc_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic pressCmd = 1'b0, multiWirePower = 1'b1, unlockTimed = 1'b0;
   logic [3:0] alarmCmd = 4'h0, reqs = 4'h0, alarmActive;
   logic keyPress, backlightOn, panelLocked, reqRejected, methodGo;
   logic [5:0] relayAlarmSel = 6'h00;
   logic [2:0] relayPolarity = 3'h0, relayCoil;
   logic [1:0] setBlMode = 2'h0, blMode;
   logic [6:0] setContrast = 7'h00, contrast;
   logic [7:0] unlockMinutes = 8'h00;
   logic [15:0] codeEntry = 16'h0000;
   int miscompares = 0, n_checks = 0;
   // ==================================================
   // Clock, 20 ns period
   always #10 core_clk = ~core_clk;
   // ==================================================
   // Partner and design
   arpc_panel_model model (.core_clk(core_clk), .pressCmd(pressCmd), .alarmCmd(alarmCmd),
      .keyPress(keyPress), .alarmActive(alarmActive));
   arpc_top #(.BL_TIMEOUT_CYC(34'h14), .RELOCK_CYC_PER_MIN(34'ha)) uut (.core_clk(core_clk), .rst(rst),
      .keyPress(keyPress), .alarmActive(alarmActive), .multiWirePower(multiWirePower),
      .relayAlarmSel(relayAlarmSel), .relayPolarity(relayPolarity), .setReq(reqs[3]),
      .setBlMode(setBlMode), .setContrast(setContrast), .methodReq(reqs[2]), .lockReq(reqs[1]),
      .unlockReq(reqs[0]), .unlockTimed(unlockTimed), .unlockMinutes(unlockMinutes),
      .codeEntry(codeEntry), .codeStored(16'h4271), .relayCoil(relayCoil), .backlightOn(backlightOn),
      .contrast(contrast), .blMode(blMode), .panelLocked(panelLocked), .reqRejected(reqRejected),
      .methodGo(methodGo));
   // ==================================================
   // Helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // One request pulse {set, method, lock, unlock}; returns just after the edge that took it
   task automatic req(input logic [3:0] r);
      @(posedge core_clk) reqs <= r;
      @(posedge core_clk) reqs <= 4'h0;
      #1;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic press();
      @(posedge core_clk) pressCmd <= 1'b1;
      @(posedge core_clk) pressCmd <= 1'b0;
   endtask
   task automatic setcfg(input logic [1:0] m, input logic [6:0] c);
      @(posedge core_clk);
      setBlMode <= m;
      setContrast <= c;
      reqs <= 4'h8;
      @(posedge core_clk) reqs <= 4'h0;
      #1;
   endtask
   task results();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==================================================
   // Watchdog: the tests need about 350 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end
   // ==================================================
   // Tests
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk(contrast, 8'h32, "contrast reset");
      chk({relayCoil, backlightOn, blMode, panelLocked}, 8'h01, "outputs at reset");
      // Locked panel refuses changes and methods
      setcfg(ARPC_BL_AUTO, 7'h10);
      chk({reqRejected, methodGo}, 8'h02, "set while locked");
      chk({blMode, contrast}, 8'h32, "settings kept while locked");
      req(4'h4);
      chk({reqRejected, methodGo}, 8'h02, "method while locked");
      // Wrong code silent, right code unlocks
      codeEntry <= 16'h4270;
      req(4'h1);
      chk(panelLocked, 8'h01, "wrong code");
      codeEntry <= 16'h4271;
      req(4'h1);
      chk(panelLocked, 8'h00, "right code");
      req(4'h4);
      chk({reqRejected, methodGo}, 8'h01, "method while open");
      setcfg(ARPC_BL_MANUAL, 7'h7f);
      chk({reqRejected, contrast}, 8'h64, "contrast top");
      setcfg(ARPC_BL_MANUAL, 7'h00);
      chk(contrast, 8'h00, "contrast bottom");
      // Relays: each follows only its own alarm, both polarities
      for (int a = 0; a < 4; a++) begin
         for (int p = 0; p < 2; p++) begin
            relayAlarmSel <= {2'((a + 2) % 4), 2'((a + 1) % 4), 2'(a)};
            relayPolarity <= {3{1'(p)}};
            alarmCmd <= 4'(1 << a);
            waitc(6);
            chk(relayCoil, {5'h0, {2{1'(p)}}, ~1'(p)}, "coil with alarm");
            alarmCmd <= 4'h0;
            waitc(6);
            chk(relayCoil, {5'h0, {3{1'(p)}}}, "coil without alarm");
         end
      end
      // Manual backlight: timeout restarts on each press
      press();
      waitc(8);
      chk(backlightOn, 8'h01, "manual on");
      waitc(8);
      press();
      waitc(14);
      chk(backlightOn, 8'h01, "second press extends");
      waitc(20);
      chk(backlightOn, 8'h00, "manual timeout");
      // Auto: an alarm holds the light
      setcfg(ARPC_BL_AUTO, 7'h32);
      alarmCmd <= 4'h4;
      waitc(40);
      chk(backlightOn, 8'h01, "auto alarm holds");
      alarmCmd <= 4'h0;
      waitc(40);
      chk(backlightOn, 8'h00, "auto off");
      // Never and always modes, then supply mode gates the light
      setcfg(ARPC_BL_NEVER, 7'h32);
      press();
      waitc(8);
      chk(backlightOn, 8'h00, "never on");
      setcfg(ARPC_BL_ALWAYS, 7'h32);
      waitc(40);
      chk({blMode, backlightOn}, 8'h07, "always on");
      multiWirePower <= 1'b0;
      waitc(6);
      chk(backlightOn, 8'h00, "two wire dark");
      multiWirePower <= 1'b1;
      waitc(6);
      chk(backlightOn, 8'h01, "power back");
      // Manual lock, then timed unlock relocks after one minute
      req(4'h2);
      chk(panelLocked, 8'h01, "lock request");
      unlockTimed <= 1'b1;
      unlockMinutes <= 8'h01;
      req(4'h1);
      chk(panelLocked, 8'h00, "timed unlock");
      waitc(6);
      chk(panelLocked, 8'h00, "still open");
      waitc(8);
      chk(panelLocked, 8'h01, "relocked");
      setcfg(ARPC_BL_MANUAL, 7'h20);
      chk({reqRejected, contrast}, 8'hb2, "relocked refuses");
      results();
   end
endmodule
`default_nettype wire
